//--- rtl/itr_pkg.sv
// Package: constants for the two-wire trim register slave.
// Assumes a 40 MHz system clock and a bus master that owns the serial clock.
package itr_pkg;
  // Bus address and register pointers
  localparam logic [6:0] ITR_SLAVE_ADDR  = 7'h28;
  localparam logic [7:0] ITR_PTR_SW_TRIM = 8'h01;
  localparam logic [7:0] ITR_PTR_LN_TRIM = 8'h02;
  localparam logic [7:0] ITR_PTR_OTP     = 8'hff;

  // Field widths and control/status bit positions
  localparam int ITR_SW_W       = 6;
  localparam int ITR_LN_W       = 4;
  localparam int ITR_BIT_RELOAD = 0;
  localparam int ITR_BIT_BURN   = 2;
  localparam int ITR_BIT_FIXED  = 3;
  localparam int ITR_BIT_BURNED = 4;

  // Values after reset; an unburned memory holds the same pattern
  localparam logic [5:0] ITR_SW_RESET  = 6'h1f;
  localparam logic [3:0] ITR_LN_RESET  = 4'h7;
  localparam logic [7:0] ITR_OTP_RESET = 8'h08;

  // Timing
  localparam int ITR_CLK_MHZ    = 40;
  localparam int ITR_READ_US    = 50;
  localparam int ITR_READ_CYC   = ITR_READ_US * ITR_CLK_MHZ;
  localparam int ITR_BURN_MS    = 25;
  localparam int ITR_BURN_CYC   = ITR_BURN_MS * 1000 * ITR_CLK_MHZ;
  localparam int ITR_RD_CNT_W   = 12;
  localparam int ITR_BURN_CNT_W = 24;

  // Serial engine states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_PTR    = 6'b000100,
    ST_WDATA  = 6'b001000,
    ST_RDATA  = 6'b010000,
    ST_IGNORE = 6'b100000
  } itr_state_t;
endpackage

//--- rtl/itr_handshake.sv
// Toggle handshake that carries one word from a source clock to a destination clock.
// Assumes each reset is synchronous to its own clock.
`timescale 1ns/100ps
module itr_handshake #(
  parameter int W = 8
) (
  // Source side
  input  wire logic         i_src_clk,
  input  wire logic         i_src_rst,
  input  wire logic         i_src_valid,
  input  wire logic [W-1:0] i_src_data,
  output logic              o_src_ready,
  // Destination side
  input  wire logic         i_dst_clk,
  input  wire logic         i_dst_rst,
  output logic              o_dst_valid,
  output logic [W-1:0]      o_dst_data
);
  logic         req_reg, req_next;
  logic [W-1:0] hold_reg, hold_next;
  logic         ack_s1_reg, ack_s2_reg;
  logic         req_s1_reg, req_s2_reg, req_s3_reg;
  logic         dv_reg;
  logic [W-1:0] dd_reg, dd_next;

  assign o_src_ready = (req_reg == ack_s2_reg);
  assign o_dst_valid = dv_reg;
  assign o_dst_data  = dd_reg;

  // Source: word held stable until the toggle comes back
  always_comb begin
    req_next  = req_reg;
    hold_next = hold_reg;
    if (i_src_valid && o_src_ready) begin
      req_next  = ~req_reg;
      hold_next = i_src_data;
    end
  end

  always_ff @(posedge i_src_clk) begin
    if (i_src_rst) begin
      req_reg    <= 1'b0;
      hold_reg   <= '0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      req_reg    <= req_next;
      hold_reg   <= hold_next;
      ack_s1_reg <= req_s3_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Destination: capture on a toggle change
  always_comb begin
    dd_next = (req_s2_reg != req_s3_reg) ? hold_reg : dd_reg;
  end

  always_ff @(posedge i_dst_clk) begin
    if (i_dst_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      dv_reg     <= 1'b0;
      dd_reg     <= '0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      dv_reg     <= (req_s2_reg != req_s3_reg);
      dd_reg     <= dd_next;
    end
  end
endmodule

//--- rtl/itr_otp_store.sv
// One-time-programmable trim store: burn timing, read cycle and burned status.
// Assumes the system clock and its synchronous reset; reset stands for power-up.
`timescale 1ns/100ps
module itr_otp_store
  import itr_pkg::*;
#(
  parameter int BURN_CYCLES = ITR_BURN_CYC
) (
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_srst,
  // Commands
  input  wire logic                i_reload,
  input  wire logic                i_burn_en,
  input  wire logic [ITR_SW_W-1:0] i_sw_trim,
  input  wire logic [ITR_LN_W-1:0] i_ln_trim,
  // Results
  output logic                     o_load,
  output logic [ITR_SW_W-1:0]      o_sw_fuse,
  output logic [ITR_LN_W-1:0]      o_ln_fuse,
  output logic                     o_burned,
  output logic                     o_reading
);
  import itr_pkg::*;

  localparam int FW = ITR_SW_W + ITR_LN_W + 1;
  localparam logic [ITR_RD_CNT_W-1:0]   RD_LAST   = ITR_RD_CNT_W'(ITR_READ_CYC - 1);
  localparam logic [ITR_BURN_CNT_W-1:0] BURN_MIN  = ITR_BURN_CNT_W'(BURN_CYCLES);
  localparam logic [ITR_BURN_CNT_W-1:0] BURN_SAT  = {ITR_BURN_CNT_W{1'b1}};

  logic [FW-1:0]             fuse_reg, fuse_next;
  logic [ITR_RD_CNT_W-1:0]   rd_cnt_reg, rd_cnt_next;
  logic [ITR_BURN_CNT_W-1:0] bcnt_reg, bcnt_next;
  logic                      reading_reg, reading_next;
  logic                      burned_reg, burned_next;
  logic                      load_reg, load_next;
  logic                      burn_prev_reg;

  assign o_load    = load_reg;
  assign o_reading = reading_reg;
  assign o_burned  = burned_reg;
  assign o_sw_fuse = fuse_reg[ITR_SW_W+ITR_LN_W-1:ITR_LN_W];
  assign o_ln_fuse = fuse_reg[ITR_LN_W-1:0];

  always_comb begin
    fuse_next    = fuse_reg;
    rd_cnt_next  = reading_reg ? rd_cnt_reg + 1'b1 : '0;
    reading_next = reading_reg;
    burned_next  = burned_reg;
    load_next    = 1'b0;
    // Read cycle copies the store into the trims
    if (reading_reg && rd_cnt_reg == RD_LAST) begin
      reading_next = 1'b0;
      load_next    = 1'b1;
      burned_next  = fuse_reg[FW-1];
    end
    if (i_reload && !reading_reg) begin
      reading_next = 1'b1;
    end
    // Burn time counted while the burn bit is high
    bcnt_next = i_burn_en ? ((bcnt_reg == BURN_SAT) ? bcnt_reg : bcnt_reg + 1'b1) : '0;
    if (burn_prev_reg && !i_burn_en && bcnt_reg >= BURN_MIN) begin
      fuse_next = {1'b1, i_sw_trim, i_ln_trim};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fuse_reg      <= {1'b0, ITR_SW_RESET, ITR_LN_RESET};
      rd_cnt_reg    <= '0;
      bcnt_reg      <= '0;
      reading_reg   <= 1'b1;
      burned_reg    <= 1'b0;
      load_reg      <= 1'b0;
      burn_prev_reg <= 1'b0;
    end else begin
      fuse_reg      <= fuse_next;
      rd_cnt_reg    <= rd_cnt_next;
      bcnt_reg      <= bcnt_next;
      reading_reg   <= reading_next;
      burned_reg    <= burned_next;
      load_reg      <= load_next;
      burn_prev_reg <= i_burn_en;
    end
  end
endmodule

//--- rtl/itr_top.sv
// Top: two-wire serial slave on the link clock and trim register bank on i_mclk.
// Assumes SCL and SDA are open-drain lines with pull-ups; i_lclk samples them fast.
`timescale 1ns/100ps

// Operation
// - Data sampled on clock high; a data change on clock high aborts the transfer.
// - Start is data falling with clock high; stop is data rising with clock high.
// - A repeated start behaves exactly like a first start.
// - Bytes are eight bits, most significant first, then one acknowledge slot.
// - Transmitter releases data on acknowledge; addressed receiver pulls it low.
// - First byte upper seven bits compared with address 0x28; answer only on match.
// - Eighth address bit selects direction: zero write, one read.
// - In a write, second byte is register pointer, third is data.
// - Written value takes effect at the rising clock of the final acknowledge.
// - Slave drives selected byte; master answers not-acknowledge then stop.
// - Decode 0x01 switching trim, 0x02 linear trim, 0xff memory control.
// - After power-up the memory is copied into both trims in about 50 us.
// - Writing one to reload bit reloads both trims; that bit reads zero.
// - Programmed status reads one after burning, updated only by a read cycle.
module itr_top
  import itr_pkg::*;
#(
  parameter int BURN_CYCLES = ITR_BURN_CYC
) (
  // System clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_srst,
  // Link clock and serial lines
  input  wire logic                i_lclk,
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda_out,
  output logic                     o_sda_oe,
  // Trim and memory status outputs
  output logic [itr_pkg::ITR_SW_W-1:0] o_switching_current_trim,
  output logic [itr_pkg::ITR_LN_W-1:0] o_linear_current_trim,
  output logic                     o_otp_burn_active,
  output logic                     o_otp_reading
);
  import itr_pkg::*;

  // ---------------- Link domain ----------------
  logic       lrst_s1_reg, lrst_s2_reg;
  logic       scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic       sda_s1_reg, sda_s2_reg, sda_d_reg;
  itr_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       oe_reg, oe_next;
  logic       mack_reg, mack_next;
  logic       wr_vld, wr_vld_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic       sda_out_reg;
  logic       snap_vld;
  logic [17:0] snap_data;
  logic [17:0] shadow_reg, shadow_next;
  logic [7:0] rd_byte;
  logic       scl_rise, scl_fall, start_det, stop_det;

  // Link reset and line synchronisers
  always_ff @(posedge i_lclk) begin
    lrst_s1_reg <= i_srst;
    lrst_s2_reg <= lrst_s1_reg;
    scl_s1_reg  <= i_scl;
    scl_s2_reg  <= scl_s1_reg;
    scl_d_reg   <= scl_s2_reg;
    sda_s1_reg  <= i_sda;
    sda_s2_reg  <= sda_s1_reg;
    sda_d_reg   <= sda_s2_reg;
  end

  assign scl_rise  = scl_s2_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_s2_reg & scl_d_reg;
  assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // Read data selection from the shadow copy
  always_comb begin
    unique case (ptr_reg)
      ITR_PTR_SW_TRIM: rd_byte = {2'h0, shadow_reg[17:12]};
      ITR_PTR_LN_TRIM: rd_byte = {4'h0, shadow_reg[11:8]};
      ITR_PTR_OTP:     rd_byte = shadow_reg[7:0];
      default:         rd_byte = 8'h00;
    endcase
  end

  // Serial engine next state
  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    ptr_next     = ptr_reg;
    oe_next      = oe_reg;
    mack_next    = mack_reg;
    wr_vld_next  = 1'b0;
    wr_data_next = wr_data_reg;
    shadow_next  = snap_vld ? snap_data : shadow_reg;
    if (start_det) begin
      // Any start, first or repeated, restarts address reception
      st_next  = ST_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end else if (stop_det) begin
      // A stop, data rising with the clock high, aborts whatever was in progress
      st_next  = ST_IDLE;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end else if (st_reg != ST_IDLE && st_reg != ST_IGNORE) begin
      if (scl_rise) begin
        if (cnt_reg < 4'h8) begin
          rx_next  = {rx_reg[6:0], sda_s2_reg};
          cnt_next = cnt_reg + 4'h1;
        end else begin
          cnt_next = 4'h9;
          if (st_reg == ST_WDATA && oe_reg) begin
            wr_vld_next = 1'b1;
          end
          mack_next = ~sda_s2_reg;
        end
      end else if (scl_fall) begin
        if (cnt_reg == 4'h8) begin
          // Acknowledge slot begins
          oe_next = 1'b1;
          unique case (st_reg)
            ST_ADDR: begin
              if (rx_reg[7:1] != ITR_SLAVE_ADDR) begin
                st_next = ST_IGNORE;
                oe_next = 1'b0;
              end
            end
            ST_PTR:   ptr_next = rx_reg;
            ST_WDATA: wr_data_next = rx_reg;
            ST_RDATA: oe_next = 1'b0;
            default:  oe_next = 1'b0;
          endcase
        end else if (cnt_reg == 4'h9) begin
          cnt_next = 4'h0;
          oe_next  = 1'b0;
          unique case (st_reg)
            ST_ADDR: begin
              if (rx_reg[0]) begin
                st_next = ST_RDATA;
                tx_next = rd_byte;
                oe_next = ~rd_byte[7];
              end else begin
                st_next = ST_PTR;
              end
            end
            ST_PTR:   st_next = ST_WDATA;
            ST_WDATA: st_next = ST_WDATA;
            ST_RDATA: begin
              if (mack_reg) begin
                tx_next = rd_byte;
                oe_next = ~rd_byte[7];
              end else begin
                st_next = ST_IGNORE;
              end
            end
            default:  st_next = st_reg;
          endcase
        end else if (st_reg == ST_RDATA && cnt_reg != 4'h0) begin
          tx_next = {tx_reg[6:0], 1'b0};
          oe_next = ~tx_reg[6];
        end
      end
    end
  end

  always_ff @(posedge i_lclk) begin
    if (lrst_s2_reg) begin
      st_reg      <= ST_IDLE;
      cnt_reg     <= 4'h0;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      oe_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      wr_vld      <= 1'b0;
      wr_data_reg <= 8'h00;
      sda_out_reg <= 1'b0;
      shadow_reg  <= {ITR_SW_RESET, ITR_LN_RESET, ITR_OTP_RESET};
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      ptr_reg     <= ptr_next;
      oe_reg      <= oe_next;
      mack_reg    <= mack_next;
      wr_vld      <= wr_vld_next;
      wr_data_reg <= wr_data_next;
      sda_out_reg <= 1'b0;
      shadow_reg  <= shadow_next;
    end
  end

  assign o_sda_out = sda_out_reg;
  assign o_sda_oe  = oe_reg;

  // ---------------- Crossings ----------------
  logic        cmd_vld;
  logic [15:0] cmd_data;

  itr_handshake #(.W(16)) u_cmd_cdc (
    .i_src_clk   (i_lclk),
    .i_src_rst   (lrst_s2_reg),
    .i_src_valid (wr_vld),
    .i_src_data  ({ptr_reg, wr_data_reg}),
    .o_src_ready (),
    .i_dst_clk   (i_mclk),
    .i_dst_rst   (i_srst),
    .o_dst_valid (cmd_vld),
    .o_dst_data  (cmd_data)
  );

  // ---------------- System domain register bank ----------------
  logic [ITR_SW_W-1:0] sw_reg, sw_next;
  logic [ITR_LN_W-1:0] ln_reg, ln_next;
  logic                burn_reg, burn_next;
  logic                reload_reg, reload_next;
  logic                otp_load, otp_burned, otp_reading;
  logic [ITR_SW_W-1:0] sw_fuse;
  logic [ITR_LN_W-1:0] ln_fuse;
  logic [7:0]          ctrl_rd;

  // Reload bit reads zero; fixed bit 3 reads one
  always_comb begin
    ctrl_rd                 = 8'h00;
    ctrl_rd[ITR_BIT_FIXED]  = ITR_OTP_RESET[ITR_BIT_FIXED];
    ctrl_rd[ITR_BIT_BURN]   = burn_reg;
    ctrl_rd[ITR_BIT_BURNED] = otp_burned;
    ctrl_rd[ITR_BIT_RELOAD] = 1'b0;
  end

  itr_handshake #(.W(18)) u_snap_cdc (
    .i_src_clk   (i_mclk),
    .i_src_rst   (i_srst),
    .i_src_valid (1'b1),
    .i_src_data  ({sw_reg, ln_reg, ctrl_rd}),
    .o_src_ready (),
    .i_dst_clk   (i_lclk),
    .i_dst_rst   (lrst_s2_reg),
    .o_dst_valid (snap_vld),
    .o_dst_data  (snap_data)
  );

  always_comb begin
    sw_next     = sw_reg;
    ln_next     = ln_reg;
    burn_next   = burn_reg;
    reload_next = 1'b0;
    if (cmd_vld) begin
      unique case (cmd_data[15:8])
        ITR_PTR_SW_TRIM: sw_next = cmd_data[ITR_SW_W-1:0];
        ITR_PTR_LN_TRIM: ln_next = cmd_data[ITR_LN_W-1:0];
        ITR_PTR_OTP: begin
          burn_next   = cmd_data[ITR_BIT_BURN];
          reload_next = cmd_data[ITR_BIT_RELOAD];
        end
        default: sw_next = sw_reg;
      endcase
    end
    if (otp_load) begin
      sw_next = sw_fuse;
      ln_next = ln_fuse;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sw_reg     <= ITR_SW_RESET;
      ln_reg     <= ITR_LN_RESET;
      burn_reg   <= 1'b0;
      reload_reg <= 1'b0;
    end else begin
      sw_reg     <= sw_next;
      ln_reg     <= ln_next;
      burn_reg   <= burn_next;
      reload_reg <= reload_next;
    end
  end

  itr_otp_store #(.BURN_CYCLES(BURN_CYCLES)) u_otp (
    .i_mclk    (i_mclk),
    .i_srst    (i_srst),
    .i_reload  (reload_reg),
    .i_burn_en (burn_reg),
    .i_sw_trim (sw_reg),
    .i_ln_trim (ln_reg),
    .o_load    (otp_load),
    .o_sw_fuse (sw_fuse),
    .o_ln_fuse (ln_fuse),
    .o_burned  (otp_burned),
    .o_reading (otp_reading)
  );

  assign o_switching_current_trim = sw_reg;
  assign o_linear_current_trim    = ln_reg;
  assign o_otp_burn_active        = burn_reg;
  assign o_otp_reading            = otp_reading;
endmodule

//--- dv/itr_top_props.sv
// Checker for the two-wire trim register slave; sees only the top module's ports.
// Assumes i_srst is held long enough to reach the link clock domain.
`timescale 1ns/100ps
module itr_top_props
  import itr_pkg::*;
#(
  parameter int BURN_CYCLES = ITR_BURN_CYC
) (
  // Clocks and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_srst,
  input  wire logic                        i_lclk,
  // Serial lines
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  input  wire logic                        o_sda_out,
  input  wire logic                        o_sda_oe,
  // Register outputs
  input  wire logic [itr_pkg::ITR_SW_W-1:0] o_switching_current_trim,
  input  wire logic [itr_pkg::ITR_LN_W-1:0] o_linear_current_trim,
  input  wire logic                        o_otp_burn_active,
  input  wire logic                        o_otp_reading
);
  localparam int RD_LO = 1995;
  localparam int RD_HI = 2005;
  logic [11:0] rd_cnt_reg;
  logic [11:0] rd_cnt_next;
  logic [3:0]  idle_reg;
  logic [3:0]  idle_next;

  // Read cycle length and time since the last read cycle
  always_comb begin
    rd_cnt_next = o_otp_reading ? rd_cnt_reg + 12'h001 : 12'h000;
    idle_next   = (o_otp_reading || i_srst) ? 4'h0 : ((idle_reg == 4'hf) ? idle_reg : idle_reg + 4'h1);
    if (i_srst) begin
      rd_cnt_next = 12'h000;
    end
  end
  always_ff @(posedge i_mclk) begin
    rd_cnt_reg <= rd_cnt_next;
    idle_reg   <= idle_next;
  end

  sequence s_scl_fall;
    $fell(i_scl);
  endsequence
  sequence s_stop;
    i_scl && $rose(i_sda);
  endsequence

  property p_rst_vals;
    @(posedge i_mclk) disable iff (i_srst) $fell(i_srst) |-> o_switching_current_trim == ITR_SW_RESET
      && o_linear_current_trim == ITR_LN_RESET && o_otp_reading && !o_otp_burn_active;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_rd_len;
    @(posedge i_mclk) disable iff (i_srst) $fell(o_otp_reading) |-> rd_cnt_reg >= RD_LO && rd_cnt_reg <= RD_HI;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle too short");
  property p_rd_max;
    @(posedge i_mclk) disable iff (i_srst) o_otp_reading |-> rd_cnt_reg <= RD_HI;
  endproperty
  a_rd_max: assert property (p_rd_max) else $error("read cycle too long");
  property p_sw_commit;
    @(posedge i_mclk) disable iff (i_srst) $changed(o_switching_current_trim) && idle_reg > 4'h8 |-> i_scl;
  endproperty
  a_sw_commit: assert property (p_sw_commit) else $error("switching trim off ack edge");
  property p_ln_commit;
    @(posedge i_mclk) disable iff (i_srst) $changed(o_linear_current_trim) && idle_reg > 4'h8 |-> i_scl;
  endproperty
  a_ln_commit: assert property (p_ln_commit) else $error("linear trim off ack edge");
  property p_sda_out;
    @(posedge i_mclk) disable iff (i_srst) o_sda_oe |-> o_sda_out == 1'b0;
  endproperty
  a_sda_out: assert property (p_sda_out) else $error("data drive not low");
  property p_oe_scl_low;
    @(posedge i_lclk) disable iff (i_srst) $changed(o_sda_oe) |-> !i_scl && !$past(i_scl);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  property p_oe_lag;
    @(posedge i_lclk) disable iff (i_srst) s_scl_fall |-> $stable(o_sda_oe) ##1 $stable(o_sda_oe);
  endproperty
  a_oe_lag: assert property (p_oe_lag) else $error("data moved too soon");
  property p_oe_hold;
    @(posedge i_lclk) disable iff (i_srst) $rose(o_sda_oe) |-> o_sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pull low not held");
  property p_oe_after_fall;
    @(posedge i_lclk) disable iff (i_srst) $rose(o_sda_oe) |-> $past(i_scl, 4) || $past(i_scl, 5) || $past(i_scl, 6);
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall) else $error("pull low not after clock fall");
  property p_stop_rel;
    @(posedge i_lclk) disable iff (i_srst) s_stop |-> !o_sda_oe [*8];
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("data driven after stop");
endmodule

bind itr_top itr_top_props #(.BURN_CYCLES(BURN_CYCLES)) u_props (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_lclk(i_lclk), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_switching_current_trim(o_switching_current_trim), .o_linear_current_trim(o_linear_current_trim),
  .o_otp_burn_active(o_otp_burn_active), .o_otp_reading(o_otp_reading));

//--- dv/itr_i2c_master.sv
// Bus master model: drives the serial clock and pulls the data line low.
// Assumes a pull-up on the data line and a free-running link clock for pacing.
`timescale 1ns/100ps
module itr_i2c_master (
  // Pacing clock and data line level
  input  wire logic i_lclk,
  input  wire logic i_sda,
  // Bus drive
  output logic      o_scl,
  output logic      o_sda_pull
);
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end
  // Half a bit time
  task automatic hp();
    repeat (40) @(posedge i_lclk);
  endtask
  // One clock pulse; data sampled at the end of the high time
  task automatic bit_io(input logic b, output logic r);
    o_sda_pull <= ~b;
    hp();
    o_scl <= 1'b1;
    hp();
    r = i_sda;
    o_scl <= 1'b0;
    @(posedge i_lclk);
  endtask
  // Start or repeated start
  task automatic start();
    @(posedge i_lclk);
    o_sda_pull <= 1'b0;
    hp();
    o_scl <= 1'b1;
    hp();
    o_sda_pull <= 1'b1;
    hp();
    o_scl <= 1'b0;
    @(posedge i_lclk);
  endtask
  task automatic stop();
    @(posedge i_lclk);
    o_sda_pull <= 1'b1;
    hp();
    o_scl <= 1'b1;
    hp();
    o_sda_pull <= 1'b0;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, r);
  endtask
endmodule

//--- dv/tb_itr_top.sv
// Testbench for the two-wire trim register slave, driven through a bus master model.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_itr_top;
  import itr_pkg::*;
  localparam int BURN = 50;
  localparam logic [7:0] WA = {ITR_SLAVE_ADDR, 1'b0};
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_lclk = 1'b1;
  logic scl;
  logic pull;
  wire  sda;
  logic o_sda_out;
  logic o_sda_oe;
  logic [ITR_SW_W-1:0] sw;
  logic [ITR_LN_W-1:0] ln;
  logic burn;
  logic reading;
  logic ack;
  logic r;
  logic [7:0] rd;
  logic [7:0] bad_adr [3] = '{8'h52, 8'hd0, 8'h11};
  int bad_count = 0;
  int comparisons = 0;

  always #12.5 i_mclk = ~i_mclk;
  always #7.5 i_lclk = ~i_lclk;
  // Open-drain data line with pull-up
  assign sda = (pull | o_sda_oe) ? 1'b0 : 1'b1;

  itr_top #(.BURN_CYCLES(BURN)) DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_lclk(i_lclk), .i_scl(scl),
    .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_switching_current_trim(sw),
    .o_linear_current_trim(ln), .o_otp_burn_active(burn), .o_otp_reading(reading));
  itr_i2c_master m (.i_lclk(i_lclk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Register write; trims must not move before the final acknowledge
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [9:0] pre;
    pre = {sw, ln};
    m.start();
    m.wbyte(WA, ack);
    `CHK("ack addr", 1'b1, ack)
    m.wbyte(p, ack);
    `CHK("ack ptr", 1'b1, ack)
    for (int i = 7; i >= 0; i--) m.bit_io(d[i], r);
    `CHK("early", pre, {sw, ln})
    m.bit_io(1'b1, r);
    `CHK("ack data", 1'b0, r)
    m.stop();
  endtask
  task automatic rdr(input logic [7:0] p, input logic [7:0] e);
    m.start();
    m.wbyte(WA, ack);
    m.wbyte(p, ack);
    m.start();
    m.wbyte({ITR_SLAVE_ADDR, 1'b1}, ack);
    `CHK("ack rd", 1'b1, ack)
    m.rbyte(1'b1, rd);
    m.stop();
    `CHK("read", e, rd)
  endtask
  task automatic wait_rd();
    int n;
    n = 0;
    while (reading === 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      $display("MISMATCH reading exp 0 got 1");
      end_sim();
    end
    // Let the trim load that follows the read cycle settle before any compare
    repeat (2) @(negedge i_mclk);
  endtask

  initial begin
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    `CHK("reading", 1'b1, reading)
    wait_rd();
    `CHK("sw rst", ITR_SW_RESET, sw)
    `CHK("ln rst", ITR_LN_RESET, ln)
    `CHK("sda out", 1'b0, o_sda_out)
    rdr(ITR_PTR_OTP, ITR_OTP_RESET);
    rdr(ITR_PTR_SW_TRIM, {2'b00, ITR_SW_RESET});
    rdr(ITR_PTR_LN_TRIM, {4'h0, ITR_LN_RESET});
    $display("test reset done");
    wr(ITR_PTR_SW_TRIM, 8'hea);
    `CHK("sw", 6'h2a, sw)
    rdr(ITR_PTR_SW_TRIM, 8'h2a);
    wr(ITR_PTR_LN_TRIM, 8'hf5);
    `CHK("ln", 4'h5, ln)
    rdr(ITR_PTR_LN_TRIM, 8'h05);
    wr(8'h10, 8'h33);
    rdr(8'h10, 8'h00);
    `CHK("sw keep", 6'h2a, sw)
    $display("test registers done");
    foreach (bad_adr[i]) begin
      m.start();
      m.wbyte(bad_adr[i], ack);
      `CHK("nack addr", 1'b0, ack)
      m.wbyte(ITR_PTR_LN_TRIM, ack);
      m.wbyte(8'h00, ack);
      `CHK("nack rest", 1'b0, ack)
      m.stop();
    end
    `CHK("ln keep", 4'h5, ln)
    m.start();
    m.wbyte(WA, ack);
    m.wbyte(ITR_PTR_LN_TRIM, ack);
    for (int i = 0; i < 3; i++) m.bit_io(1'b0, r);
    m.stop();
    `CHK("abort", 4'h5, ln)
    m.start();
    m.wbyte(WA, ack);
    m.wbyte(ITR_PTR_SW_TRIM, ack);
    wr(ITR_PTR_LN_TRIM, 8'h03);
    `CHK("restart", 4'h3, ln)
    `CHK("sw same", 6'h2a, sw)
    $display("test bus errors done");
    wr(ITR_PTR_OTP, 8'h04);
    `CHK("burn", 1'b1, burn)
    repeat (BURN + 10) @(posedge i_mclk);
    wr(ITR_PTR_OTP, 8'h00);
    `CHK("burn off", 1'b0, burn)
    rdr(ITR_PTR_OTP, 8'h08);
    wr(ITR_PTR_SW_TRIM, 8'h05);
    wr(ITR_PTR_OTP, 8'h01);
    `CHK("reload", 1'b1, reading)
    wait_rd();
    `CHK("sw load", 6'h2a, sw)
    `CHK("ln load", 4'h3, ln)
    rdr(ITR_PTR_OTP, 8'h18);
    $display("test memory done");
    end_sim();
  end
endmodule
